// [pkg/rtc_pkg.sv]
package rtc_pkg;

  // Register map, reset values and writable-bit masks.
  localparam logic [15:0] RTC_ADDR_CLK_SEL   = 16'hFF54;
  localparam logic [15:0] RTC_ADDR_CTRL0     = 16'hFF89;
  localparam logic [7:0]  RTC_CLK_SEL_RESET  = 8'h00;
  localparam logic [7:0]  RTC_CTRL0_RESET    = 8'h00;
  localparam logic [7:0]  RTC_CLK_SEL_MASK   = 8'h03;
  localparam logic [7:0]  RTC_CTRL0_MASK     = 8'hBF;

  // Field positions in control register zero.
  localparam int          RTC_RUN_BIT        = 7;
  localparam int          RTC_ONE_HZ_BIT     = 5;
  localparam int          RTC_FAST_BIT       = 4;
  localparam int          RTC_HOUR_FMT_BIT   = 3;
  localparam int          RTC_PERIOD_MSB     = 2;

  // Prescaler and sub-count stage.
  localparam int          RTC_PRESCALE_W     = 8;
  localparam int          RTC_SUB_DIV        = 32768;
  localparam int          RTC_SUB_W          = 15;
  localparam logic [14:0] RTC_SUB_LAST       = 15'(RTC_SUB_DIV - 1);
  localparam logic [14:0] RTC_SUB_HALF       = 15'(RTC_SUB_DIV / 2 - 1);

  // Calendar reset values and limits, all BCD.
  localparam logic [7:0]  RTC_SEC_RESET      = 8'h00;
  localparam logic [7:0]  RTC_MIN_RESET      = 8'h00;
  localparam logic [7:0]  RTC_HOUR_RESET     = 8'h12;
  localparam logic [7:0]  RTC_DAY_RESET      = 8'h01;
  localparam logic [7:0]  RTC_WEEK_RESET     = 8'h00;
  localparam logic [7:0]  RTC_MONTH_RESET    = 8'h01;
  localparam logic [7:0]  RTC_YEAR_RESET     = 8'h00;
  localparam logic [7:0]  RTC_SEC_MAX        = 8'h59;
  localparam logic [7:0]  RTC_WEEK_MAX       = 8'h06;
  localparam logic [7:0]  RTC_MONTH_MAX      = 8'h12;
  localparam logic [7:0]  RTC_YEAR_MAX       = 8'h99;
  localparam logic [7:0]  RTC_H24_MIN        = 8'h00;
  localparam logic [7:0]  RTC_H24_MAX        = 8'h23;
  localparam logic [7:0]  RTC_AM12           = 8'h12;
  localparam logic [7:0]  RTC_AM1            = 8'h01;
  localparam logic [7:0]  RTC_AM11           = 8'h11;
  localparam logic [7:0]  RTC_PM12           = 8'h32;
  localparam logic [7:0]  RTC_PM1            = 8'h21;
  localparam logic [7:0]  RTC_PM11           = 8'h31;

  typedef enum logic [1:0] {
    RTC_SRC_SUB    = 2'h0,
    RTC_SRC_DIV128 = 2'h1,
    RTC_SRC_DIV256 = 2'h2,
    RTC_SRC_NONE   = 2'h3
  } rtc_clk_src_t;

  typedef enum logic [2:0] {
    RTC_PER_OFF   = 3'h0,
    RTC_PER_HALF  = 3'h1,
    RTC_PER_SEC   = 3'h2,
    RTC_PER_MIN   = 3'h3,
    RTC_PER_HOUR  = 3'h4,
    RTC_PER_DAY   = 3'h5,
    RTC_PER_MONTH = 3'h6,
    RTC_PER_MON2  = 3'h7
  } rtc_period_t;

  function automatic logic [7:0] rtc_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

endpackage

// [core/rtc_clk_src.sv]
`timescale 1ns/1ps
module rtc_clk_src
  import rtc_pkg::*;
#(
  parameter int PRESCALE_W = RTC_PRESCALE_W
) (
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // Source selection and subsystem clock pin.
  input  wire rtc_pkg::rtc_clk_src_t i_sel,
  input  wire logic                  i_subsystem_clock,
  // Counter input clock as a level and a rising-edge pulse.
  output logic                       o_level,
  output logic                       o_tick
);
  import rtc_pkg::*;

  logic                  sub_meta;
  logic                  sub_sync;
  logic [PRESCALE_W-1:0] prescale;
  logic                  next_level;

  // The divided peripheral clock is taken from the prescaler bits.
  always_comb begin
    case (i_sel)
      RTC_SRC_SUB:    next_level = sub_sync;
      RTC_SRC_DIV128: next_level = prescale[6];
      RTC_SRC_DIV256: next_level = prescale[7];
      default:        next_level = 1'b0; // Prohibited code stops the clock.
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sub_meta <= 1'b0;
      sub_sync <= 1'b0;
      prescale <= '0;
      o_level  <= 1'b0;
    end else begin
      sub_meta <= i_subsystem_clock;
      sub_sync <= sub_meta;
      prescale <= prescale + 1'b1;
      o_level  <= next_level;
    end
  end

  assign o_tick = next_level & ~o_level;

endmodule // rtc_clk_src

// [core/rtc_bcd_counter.sv]
`timescale 1ns/1ps
module rtc_bcd_counter
  import rtc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Count request and BCD limits.
  input  wire logic       i_inc,
  input  wire logic [7:0] i_min,
  input  wire logic [7:0] i_max,
  // Count value and carry to the next stage.
  output logic [7:0]      o_value,
  output logic            o_wrap
);
  import rtc_pkg::*;

  // A value beyond the limit also wraps, so a shortened month recovers.
  assign o_wrap = i_inc & (o_value >= i_max);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_value <= RESET_VAL;
    end else if (o_wrap) begin
      o_value <= i_min;
    end else if (i_inc) begin
      o_value <= rtc_bcd_inc(o_value);
    end
  end

endmodule // rtc_bcd_counter

// [core/rtc_control.sv]
`timescale 1ns/1ps
module rtc_control
  import rtc_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Memory-manipulation access.
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_bit_wr,
  input  wire logic [2:0]  i_bit_pos,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata,
  // Counter wait and hour rewrite from the second control register.
  input  wire logic        i_counter_wait_request,
  input  wire logic        i_hour_wr,
  input  wire logic [7:0]  i_hour_wdata,
  // Subsystem clock pin.
  input  wire logic        i_subsystem_clock,
  // Pin outputs.
  output logic             o_one_hz_pin,
  output logic             o_fast_clock_pin,
  // Constant-period request to the shared interrupt.
  output logic             o_period_event,
  // Calendar values, BCD.
  output logic [7:0]       o_second,
  output logic [7:0]       o_minute,
  output logic [7:0]       o_hour,
  output logic [7:0]       o_day,
  output logic [7:0]       o_week,
  output logic [7:0]       o_month,
  output logic [7:0]       o_year
);
  import rtc_pkg::*;

  // Registers and their fields.
  logic [7:0]           clock_source_register_and_fast_clock_pin;
  logic [7:0]           control_register_zero;
  logic                 counter_run_enable;
  logic                 one_hz_output_enable;
  logic                 fast_clock_output_enable;
  logic                 hour_format_select;
  rtc_period_t          period_select;
  rtc_clk_src_t         clock_source;

  // Bus decode.
  logic                 hit_clk_sel;
  logic                 hit_ctrl0;
  logic                 any_write;
  logic [7:0]           next_clk_sel;
  logic [7:0]           next_ctrl0;
  logic [7:0]           read_mux;

  // Clocking and sub-count.
  logic                 frtc_level;
  logic                 frtc_tick;
  logic [RTC_SUB_W-1:0] sub_count;
  logic                 sub_overflow;
  logic                 half_event;
  logic                 second_pending;
  logic                 second_step;

  // Calendar chain.
  logic                 sec_wrap;
  logic                 min_wrap;
  logic                 hour_inc;
  logic                 hour_wrap;
  logic                 day_wrap;
  logic                 month_wrap;
  logic [7:0]           month_days;
  logic [7:0]           next_hour;
  logic                 next_period_event;

  // Replaces one bit of a register image for a single-bit write.
  function automatic logic [7:0] merge_bit(input logic [7:0] old, input logic [2:0] pos,
                                           input logic val);
    logic [7:0] res;
    res      = old;
    res[pos] = val;
    return res;
  endfunction

  // Days in a month; every year divisible by four is a leap year in 00 to 99.
  function automatic logic [7:0] days_in_month(input logic [7:0] month,
                                               input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  assign counter_run_enable       = control_register_zero[RTC_RUN_BIT];
  assign one_hz_output_enable     = control_register_zero[RTC_ONE_HZ_BIT];
  assign fast_clock_output_enable = control_register_zero[RTC_FAST_BIT];
  assign hour_format_select       = control_register_zero[RTC_HOUR_FMT_BIT];
  assign period_select            = rtc_period_t'(control_register_zero[RTC_PERIOD_MSB:0]);
  assign clock_source             = rtc_clk_src_t'(clock_source_register_and_fast_clock_pin[1:0]);

  // Register access: a byte write stores the data, a bit write changes one bit only.
  assign hit_clk_sel  = (i_addr == RTC_ADDR_CLK_SEL);
  assign hit_ctrl0    = (i_addr == RTC_ADDR_CTRL0);
  assign any_write    = i_wr | i_bit_wr;
  assign next_clk_sel = RTC_CLK_SEL_MASK & (i_bit_wr
                        ? merge_bit(clock_source_register_and_fast_clock_pin, i_bit_pos,
                                    i_wdata[0])
                        : i_wdata);
  assign next_ctrl0   = RTC_CTRL0_MASK & (i_bit_wr
                        ? merge_bit(control_register_zero, i_bit_pos, i_wdata[0])
                        : i_wdata);
  assign read_mux     = hit_clk_sel ? clock_source_register_and_fast_clock_pin
                      : hit_ctrl0   ? control_register_zero
                      : 8'h00;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clock_source_register_and_fast_clock_pin <= RTC_CLK_SEL_RESET;
      control_register_zero                    <= RTC_CTRL0_RESET;
      o_rdata                                  <= 8'h00;
    end else begin
      if (any_write && hit_clk_sel) begin
        clock_source_register_and_fast_clock_pin <= next_clk_sel;
      end
      if (any_write && hit_ctrl0) begin
        control_register_zero <= next_ctrl0;
      end
      if (i_rd) begin
        o_rdata <= read_mux;
      end
    end
  end

  rtc_clk_src u_clk_src (
    .i_clk             (i_clk),
    .i_reset_n         (i_reset_n),
    .i_sel             (clock_source),
    .i_subsystem_clock (i_subsystem_clock),
    .o_level           (frtc_level),
    .o_tick            (frtc_tick)
  );

  // The sub-count keeps running during a wait so the time base is not lost.
  assign sub_overflow = frtc_tick & counter_run_enable & (sub_count == RTC_SUB_LAST);
  assign half_event   = frtc_tick & counter_run_enable & (sub_count == RTC_SUB_HALF);
  assign second_step  = counter_run_enable & ~i_counter_wait_request
                      & (sub_overflow | second_pending);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sub_count      <= '0;
      second_pending <= 1'b0;
    end else begin
      if (frtc_tick && counter_run_enable) begin
        sub_count <= sub_count + 1'b1;
      end
      // An overflow during a wait is held and counted once the wait ends.
      if (i_counter_wait_request) begin
        second_pending <= second_pending | sub_overflow;
      end else begin
        second_pending <= 1'b0;
      end
    end
  end

  rtc_bcd_counter #(.RESET_VAL(RTC_SEC_RESET)) u_second (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_inc     (second_step),
    .i_min     (RTC_SEC_RESET),
    .i_max     (RTC_SEC_MAX),
    .o_value   (o_second),
    .o_wrap    (sec_wrap)
  );

  rtc_bcd_counter #(.RESET_VAL(RTC_MIN_RESET)) u_minute (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_inc     (sec_wrap),
    .i_min     (RTC_MIN_RESET),
    .i_max     (RTC_SEC_MAX),
    .o_value   (o_minute),
    .o_wrap    (min_wrap)
  );

  // Hour sequence in 12-hour mode: 12, 01..11, 32, 21..31, then back to 12.
  assign hour_inc  = min_wrap;
  assign hour_wrap = hour_inc & (hour_format_select ? (o_hour >= RTC_H24_MAX)
                                                    : (o_hour == RTC_PM11));

  always_comb begin
    if (hour_format_select) begin
      next_hour = (o_hour >= RTC_H24_MAX) ? RTC_H24_MIN : rtc_bcd_inc(o_hour);
    end else begin
      case (o_hour)
        RTC_AM12: next_hour = RTC_AM1;
        RTC_AM11: next_hour = RTC_PM12;
        RTC_PM12: next_hour = RTC_PM1;
        RTC_PM11: next_hour = RTC_AM12;
        default:  next_hour = rtc_bcd_inc(o_hour);
      endcase
    end
  end

  // The hour is not re-encoded on a format change; software rewrites it under wait.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hour <= RTC_HOUR_RESET;
    end else if (i_hour_wr) begin
      o_hour <= i_hour_wdata;
    end else if (hour_inc) begin
      o_hour <= next_hour;
    end
  end

  assign month_days = days_in_month(o_month, o_year);

  rtc_bcd_counter #(.RESET_VAL(RTC_DAY_RESET)) u_day (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_inc     (hour_wrap),
    .i_min     (RTC_DAY_RESET),
    .i_max     (month_days),
    .o_value   (o_day),
    .o_wrap    (day_wrap)
  );

  rtc_bcd_counter #(.RESET_VAL(RTC_WEEK_RESET)) u_week (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_inc     (hour_wrap),
    .i_min     (RTC_WEEK_RESET),
    .i_max     (RTC_WEEK_MAX),
    .o_value   (o_week),
    .o_wrap    ()
  );

  rtc_bcd_counter #(.RESET_VAL(RTC_MONTH_RESET)) u_month (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_inc     (day_wrap),
    .i_min     (RTC_MONTH_RESET),
    .i_max     (RTC_MONTH_MAX),
    .o_value   (o_month),
    .o_wrap    (month_wrap)
  );

  rtc_bcd_counter #(.RESET_VAL(RTC_YEAR_RESET)) u_year (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_inc     (month_wrap),
    .i_min     (RTC_YEAR_RESET),
    .i_max     (RTC_YEAR_MAX),
    .o_value   (o_year),
    .o_wrap    ()
  );

  // Constant-period selection; from the second up, each event is the carry out of the stage below.
  always_comb begin
    case (period_select)
      RTC_PER_OFF:  next_period_event = 1'b0;
      RTC_PER_HALF: next_period_event = half_event | second_step;
      RTC_PER_SEC:  next_period_event = second_step;
      RTC_PER_MIN:  next_period_event = sec_wrap;
      RTC_PER_HOUR: next_period_event = min_wrap;
      RTC_PER_DAY:  next_period_event = hour_wrap;
      default:      next_period_event = day_wrap;
    endcase
  end

  // Pin gating is registered; a mid-phase enable change can still give a short
  // pulse, which is why the 1 Hz enable should only move while counting is stopped.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_one_hz_pin     <= 1'b0;
      o_fast_clock_pin <= 1'b0;
      o_period_event   <= 1'b0;
    end else begin
      o_one_hz_pin     <= one_hz_output_enable & counter_run_enable
                          & sub_count[RTC_SUB_W-1];
      o_fast_clock_pin <= fast_clock_output_enable & frtc_level;
      o_period_event   <= next_period_event;
    end
  end

endmodule // rtc_control

// [dv/rtc_control_asserts.sv]
`timescale 1ns/1ps
module rtc_control_asserts
  import rtc_pkg::*;
(
  // Clock, reset and register access.
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_bit_wr,
  input wire logic [2:0]  i_bit_pos,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // Pins, event and calendar.
  input wire logic        o_one_hz_pin,
  input wire logic        o_fast_clock_pin,
  input wire logic        o_period_event,
  input wire logic [7:0]  o_second,
  input wire logic [7:0]  o_hour,
  input wire logic [7:0]  o_day,
  input wire logic [7:0]  o_month
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // A shadow of control register zero lets pin rules refer to the stored enables.
  logic [7:0] ctl;
  wire        ctl_sel = i_addr == RTC_ADDR_CTRL0;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) ctl <= 8'h00;
    else if (i_bit_wr && ctl_sel) ctl[i_bit_pos] <= i_wdata[0] & RTC_CTRL0_MASK[i_bit_pos];
    else if (i_wr && ctl_sel) ctl <= i_wdata & RTC_CTRL0_MASK;
  end
  property p_reset;
    $rose(i_reset_n) |-> o_hour == 8'h12 && o_day == 8'h01 && o_month == 8'h01 && o_second == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("calendar not at reset value");
  property p_clk_mask;
    i_rd && i_addr == RTC_ADDR_CLK_SEL |=> o_rdata[7:2] == 6'h00;
  endproperty
  a_clk_mask: assert property (p_clk_mask) else $error("clock select high bits set");
  property p_ctrl_rd;
    i_rd && ctl_sel |=> o_rdata == $past(ctl);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read differs from writes");
  property p_unmapped;
    i_rd && !ctl_sel && i_addr != RTC_ADDR_CLK_SEL |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_one_hz_off;
    !ctl[RTC_ONE_HZ_BIT] |=> !o_one_hz_pin;
  endproperty
  a_one_hz_off: assert property (p_one_hz_off) else $error("1 Hz pin active while off");
  property p_fast_off;
    !ctl[RTC_FAST_BIT] |=> !o_fast_clock_pin;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast pin active while off");
  property p_stop;
    !ctl[RTC_RUN_BIT] |=> $stable(o_second);
  endproperty
  a_stop: assert property (p_stop) else $error("seconds moved while stopped");
  property p_per_off;
    ctl[2:0] == 3'h0 |=> !o_period_event;
  endproperty
  a_per_off: assert property (p_per_off) else $error("period event while off");
  property p_pulse;
    o_period_event |=> !o_period_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("period event longer than a cycle");
  property p_sec_event;
    ctl[2:0] == 3'h2 && $changed(o_second) |-> $past(o_period_event) or ##[0:1] o_period_event;
  endproperty
  a_sec_event: assert property (p_sec_event) else $error("no event at second step");
endmodule // rtc_control_asserts

bind rtc_control rtc_control_asserts u_rtc_control_asserts (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr(i_wr), .i_bit_wr(i_bit_wr),
  .i_bit_pos(i_bit_pos), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_one_hz_pin(o_one_hz_pin), .o_fast_clock_pin(o_fast_clock_pin),
  .o_period_event(o_period_event), .o_second(o_second), .o_hour(o_hour), .o_day(o_day),
  .o_month(o_month));

// [dv/rtc_control_test.sv]
`timescale 1ns/1ps
module rtc_control_test;
  import rtc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_bit_wr = 1'b0;
  logic [2:0]  i_bit_pos = 3'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_rd = 1'b0;
  logic        i_counter_wait_request = 1'b0;
  logic        i_hour_wr = 1'b0;
  logic [7:0]  i_hour_wdata = 8'h00;
  logic        i_subsystem_clock = 1'b0;
  logic        sub_run = 1'b0;
  logic [7:0]  o_rdata, o_second, o_minute, o_hour, o_day, o_week, o_month, o_year;
  logic        o_one_hz_pin, o_fast_clock_pin, o_period_event;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #4 i_clk = ~i_clk;
  // The subsystem clock toggles every cycle so a second fits in a short run.
  always @(negedge i_clk) if (sub_run) i_subsystem_clock <= ~i_subsystem_clock;

  rtc_control u_rtc_control (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wr(i_wr), .i_bit_wr(i_bit_wr), .i_bit_pos(i_bit_pos), .i_wdata(i_wdata), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_counter_wait_request(i_counter_wait_request),
    .i_hour_wr(i_hour_wr), .i_hour_wdata(i_hour_wdata), .i_subsystem_clock(i_subsystem_clock),
    .o_one_hz_pin(o_one_hz_pin), .o_fast_clock_pin(o_fast_clock_pin),
    .o_period_event(o_period_event), .o_second(o_second), .o_minute(o_minute),
    .o_hour(o_hour), .o_day(o_day), .o_week(o_week), .o_month(o_month), .o_year(o_year));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bit_mode, input int p);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    i_bit_pos = 3'(p);
    i_wr = !bit_mode;
    i_bit_wr = bit_mode;
    @(negedge i_clk);
    i_wr = 1'b0;
    i_bit_wr = 1'b0;
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    @(negedge i_clk);
    check(o_rdata, exp);
  endtask

  task automatic until_pin(input logic v, inout int c);
    while (o_fast_clock_pin !== v && c < 1000) begin
      @(negedge i_clk);
      c++;
    end
  endtask

  task automatic toggles(output int ch);
    logic last;
    ch = 0;
    repeat (4) @(negedge i_clk);
    last = o_fast_clock_pin;
    repeat (300) begin
      @(negedge i_clk);
      if (o_fast_clock_pin !== last) ch++;
      last = o_fast_clock_pin;
    end
  endtask

  task automatic t_regs;
    rc(RTC_ADDR_CLK_SEL, 8'h00);
    rc(RTC_ADDR_CTRL0, 8'h00);
    check(o_hour, 8'h12);
    check(o_minute, RTC_MIN_RESET);
    check(o_day, RTC_DAY_RESET);
    check(o_week, RTC_WEEK_RESET);
    check(o_month, RTC_MONTH_RESET);
    check(o_year, RTC_YEAR_RESET);
    wr(RTC_ADDR_CLK_SEL, 8'hFF, 1'b0, 0);
    rc(RTC_ADDR_CLK_SEL, 8'h03);
    wr(RTC_ADDR_CLK_SEL, 8'h00, 1'b1, 0);
    wr(RTC_ADDR_CLK_SEL, 8'h01, 1'b1, 5);
    rc(RTC_ADDR_CLK_SEL, 8'h02);
    wr(RTC_ADDR_CTRL0, 8'hFF, 1'b0, 0);
    rc(RTC_ADDR_CTRL0, 8'hBF);
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b1, RTC_RUN_BIT);
    rc(RTC_ADDR_CTRL0, 8'h3F);
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b0, 0);
    wr(RTC_ADDR_CTRL0, 8'h01, 1'b1, 6);
    wr(16'hFF8A, 8'h5A, 1'b0, 0);
    rc(RTC_ADDR_CTRL0, 8'h00);
    rc(16'hFF8A, 8'h00);
    $display("register access test done");
  endtask

  task automatic t_src;
    int n;
    int c;
    for (int k = 1; k <= 2; k++) begin
      wr(RTC_ADDR_CLK_SEL, 8'(k), 1'b0, 0);
      wr(RTC_ADDR_CTRL0, 8'h10, 1'b0, 0);
      c = 0;
      until_pin(1'b0, c);
      until_pin(1'b1, c);
      c = 0;
      until_pin(1'b0, c);
      until_pin(1'b1, c);
      check(8'(c >> 1), 8'(64 << (k - 1)));
    end
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b0, 0);
    toggles(n);
    check({7'h00, o_fast_clock_pin} | 8'(n), 8'h00);
    wr(RTC_ADDR_CTRL0, 8'h10, 1'b0, 0);
    wr(RTC_ADDR_CLK_SEL, 8'h03, 1'b0, 0);
    toggles(n);
    check(8'(n), 8'h00);
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b0, 0);
    $display("clock source test done");
  endtask

  task automatic t_run;
    logic hz;
    logic ev;
    int   c;
    hz = 1'b0;
    c = 0;
    wr(RTC_ADDR_CLK_SEL, 8'h00, 1'b0, 0);
    sub_run = 1'b1;
    wr(RTC_ADDR_CTRL0, 8'hA1, 1'b0, 0);
    // The bench's event flag stands for the shared request flag.
    ev = 1'b0;
    while (!ev && c < 70000) begin
      @(negedge i_clk);
      c++;
      ev = o_period_event;
    end
    // The half-second event must come before the first second step.
    check(o_second, 8'h00);
    check({7'h00, ev}, 8'h01);
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b1, 0);
    wr(RTC_ADDR_CTRL0, 8'h01, 1'b1, 1);
    ev = 1'b0;
    while (o_second === 8'h00 && c < 70000) begin
      @(negedge i_clk);
      c++;
      hz |= o_one_hz_pin;
      ev |= o_period_event;
    end
    repeat (2) begin
      @(negedge i_clk);
      ev |= o_period_event;
    end
    check(o_second, 8'h01);
    // One tick every two cycles, so a second is twice the sub-count divide.
    check(8'((c + 2048) >> 12), 8'((2 * RTC_SUB_DIV) >> 12));
    check({7'h00, hz}, 8'h01);
    check({7'h00, ev}, 8'h01);
    // Stop counting before the pin enable moves, so no narrow pulse appears.
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b1, RTC_RUN_BIT);
    wr(RTC_ADDR_CTRL0, 8'h00, 1'b0, 0);
    sub_run = 1'b0;
    $display("run test done");
  endtask

  task automatic t_hour;
    for (int k = 1; k >= 0; k--) begin
      @(negedge i_clk);
      i_counter_wait_request = 1'b1;
      wr(RTC_ADDR_CTRL0, 8'(k), 1'b1, RTC_HOUR_FMT_BIT);
      rc(RTC_ADDR_CTRL0, 8'(k << 3));
      @(negedge i_clk);
      i_hour_wdata = k ? 8'h23 : 8'h32;
      i_hour_wr = 1'b1;
      @(negedge i_clk);
      i_hour_wr = 1'b0;
      @(negedge i_clk);
      i_counter_wait_request = 1'b0;
      check(o_hour, k ? 8'h23 : 8'h32);
    end
    $display("hour format test done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_reset_n = 1'b1;
    t_regs;
    t_src;
    t_run;
    t_hour;
    print_verdict;
  end

  // The longest test waits one counted second of about 65536 cycles.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      print_verdict;
    end
  end
endmodule // rtc_control_test
